//--- rtl/fpu_exc_ctrl.sv
// Top of the FPU exception control: issue, interlock, result routing,
// exception request and the software-visible registers.
// Assumes the core issues only while o_fp_ready is high and the datapath
// answers each start with exactly one done.
`timescale 1ns/1ns

module fpu_exc_ctrl (
	input  wire logic              i_sys_clk,
	input  wire logic              i_rst,
	input  wire logic        [3:0] i_reg_addr,
	input  wire logic       [31:0] i_reg_wdata,
	input  wire logic              i_reg_wr,
	input  wire logic              i_reg_rd,
	output logic            [31:0] o_reg_rdata,
	input  fpu_exc_pkg::op_req_t   i_op,
	input  fpu_exc_pkg::dp_resp_t  i_dp_resp,
	input  wire logic              i_exc_ack,
	output fpu_exc_pkg::dp_start_t o_dp_start,
	output fpu_exc_pkg::fr_wr_t    o_fr_wr,
	output fpu_exc_pkg::gpr_upd_t  o_gpr_upd,
	output fpu_exc_pkg::word_out_t o_cpu_wr,
	output logic                   o_t_valid,
	output logic                   o_t_value,
	output logic                   o_fp_ready,
	output logic                   o_stall_core,
	output logic                   o_exc_req,
	output logic            [31:0] o_exc_vector,
	output logic                   o_illegal_trap,
	output logic                   o_addr_err
);
	import fpu_exc_pkg::*;

	// Memory accesses share the alignment and address-update decode
	function automatic logic is_mem_op(input op_kind_t k);
		is_mem_op = (k == OP_LOAD) || (k == OP_STORE);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// State and registers
	ctrl_state_t state_reg;
	ctrl_state_t state_next;
	op_kind_t    pend_kind_reg;
	logic  [3:0] pend_dest_reg;
	logic [31:0] pend_a_reg;
	logic [31:0] pend_b_reg;
	logic        pend_sync_reg;
	logic [31:0] transfer_reg;
	logic        standby_reg;

	logic [31:0] scr;
	logic        accept;
	logic        issue;
	logic        misaligned;
	logic        dp_op;
	logic        finish;
	logic        sc_load;
	logic        sc_wr;
	logic [31:0] sc_wr_data;
	logic [31:0] fix_data;
	logic        fix_cause_v;
	logic        fix_cause_z;
	logic        fix_trap;
	logic [31:0] flush_a;
	logic [31:0] flush_b;

	////////////////////////////////////////////////////////////////////////////
	// Issue decode
	always_comb begin
		accept     = i_op.valid && (state_reg == ST_IDLE) && !standby_reg;
		dp_op      = uses_datapath(i_op.kind);
		// Misaligned memory ops are refused whole
		misaligned = is_mem_op(i_op.kind) && (i_op.addr_lo != 2'b00);
		issue      = accept && !misaligned;
		finish     = (state_reg == ST_BUSY) && i_dp_resp.done;
		flush_a    = (i_op.kind == OP_FLOAT) ? transfer_reg : flush_dn(i_op.a);
		flush_b    = flush_dn(i_op.b);
	end

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (issue && dp_op) begin
					state_next = ST_BUSY;
				end
			end
			ST_BUSY: begin
				if (finish) begin
					state_next = fix_trap ? ST_EXC : ST_IDLE;
				end
			end
			ST_EXC: begin
				if (i_exc_ack) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pending datapath operation
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			pend_kind_reg <= OP_ADD;
			pend_dest_reg <= 4'h0;
			pend_a_reg    <= 32'h0000_0000;
			pend_b_reg    <= 32'h0000_0000;
			pend_sync_reg <= 1'b0;
		end else if (issue && dp_op) begin
			pend_kind_reg <= i_op.kind;
			pend_dest_reg <= i_op.dest;
			pend_a_reg    <= flush_a;
			pend_b_reg    <= flush_b;
			pend_sync_reg <= needs_sync(i_op.kind);
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_dp_start <= '0;
		end else begin
			o_dp_start.valid <= issue && dp_op;
			o_dp_start.kind  <= i_op.kind;
			o_dp_start.a     <= flush_a;
			o_dp_start.b     <= flush_b;
		end
	end

	fpu_special_result u_special (
		.i_kind    (pend_kind_reg),
		.i_a       (pend_a_reg),
		.i_b       (pend_b_reg),
		.i_resp    (i_dp_resp),
		.i_en_v    (scr[EN_V_BIT]),
		.i_en_z    (scr[EN_Z_BIT]),
		.o_data    (fix_data),
		.o_cause_v (fix_cause_v),
		.o_cause_z (fix_cause_z),
		.o_trap    (fix_trap)
	);

	////////////////////////////////////////////////////////////////////////////
	// Status/control, transfer and standby registers
	always_comb begin
		// Instruction store wins over a same-cycle bus write
		sc_load    = issue && (i_op.kind == OP_LDS_SC);
		sc_wr      = sc_load || (i_reg_wr && (i_reg_addr == OFS_STATUS_CTRL));
		sc_wr_data = sc_load ? i_op.b : i_reg_wdata;
	end

	fpu_status_ctrl u_status (
		.i_sys_clk    (i_sys_clk),
		.i_rst        (i_rst),
		.i_sw_wr      (sc_wr),
		.i_sw_data    (sc_wr_data),
		.i_hw_upd     (finish),
		.i_hw_cause_v (fix_cause_v),
		.i_hw_cause_z (fix_cause_z),
		.o_scr        (scr)
	);

	// Instruction writes win over a same-cycle bus write
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			transfer_reg <= TRANSFER_RESET;
		end else if (finish && !fix_trap && (pend_kind_reg == OP_TRUNC)) begin
			transfer_reg <= fix_data;
		end else if (issue && (i_op.kind == OP_LDS_XFER)) begin
			transfer_reg <= i_op.b;
		end else if (i_reg_wr && (i_reg_addr == OFS_TRANSFER)) begin
			transfer_reg <= i_reg_wdata;
		end
	end

	// Only the standby bit is writable
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			standby_reg <= STANDBY_RESET;
		end else if (i_reg_wr && (i_reg_addr == OFS_STANDBY)) begin
			standby_reg <= i_reg_wdata[STANDBY_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register read port, data stand one cycle after the strobe
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_reg_rdata <= 32'h0000_0000;
		end else if (i_reg_rd) begin
			case (i_reg_addr)
				OFS_STATUS_CTRL: o_reg_rdata <= scr;
				OFS_TRANSFER:    o_reg_rdata <= transfer_reg;
				OFS_STANDBY:     o_reg_rdata <= {30'h0000_0000, standby_reg, 1'b0};
				default:         o_reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			o_reg_rdata <= 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Result routing
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_fr_wr <= '0;
		end else if (finish) begin
			o_fr_wr.valid <= !fix_trap && (pend_kind_reg != OP_CMP) && (pend_kind_reg != OP_TRUNC);
			o_fr_wr.idx   <= pend_dest_reg;
			o_fr_wr.data  <= fix_data;
		end else begin
			o_fr_wr.valid <= issue && ((i_op.kind == OP_MOV) || (i_op.kind == OP_LOAD));
			o_fr_wr.idx   <= i_op.dest;
			o_fr_wr.data  <= i_op.a;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_t_valid <= 1'b0;
			o_t_value <= 1'b0;
		end else begin
			o_t_valid <= finish && !fix_trap && (pend_kind_reg == OP_CMP);
			// Meaningful only beside o_t_valid
			o_t_value <= i_dp_resp.cmp_true && !fix_cause_v;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_gpr_upd <= '0;
		end else begin
			o_gpr_upd.valid <= issue && i_op.addr_upd && is_mem_op(i_op.kind);
			o_gpr_upd.idx   <= i_op.gpr;
			o_gpr_upd.inc   <= (i_op.kind == OP_LOAD);
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_cpu_wr <= '0;
		end else begin
			// Store data and register copies toward the core
			o_cpu_wr.valid <= issue && ((i_op.kind == OP_STORE) || (i_op.kind == OP_STS_SC) ||
					(i_op.kind == OP_STS_XFER));
			case (i_op.kind)
				OP_STS_SC:   o_cpu_wr.data <= scr;
				OP_STS_XFER: o_cpu_wr.data <= transfer_reg;
				default:     o_cpu_wr.data <= i_op.a;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Handshakes toward the core
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_fp_ready   <= 1'b1;
			o_stall_core <= 1'b0;
		end else begin
			o_fp_ready   <= (state_next == ST_IDLE);
			// FP-only work runs behind the core
			if (state_next == ST_BUSY) begin
				o_stall_core <= (state_reg == ST_IDLE) ? needs_sync(i_op.kind) : pend_sync_reg;
			end else begin
				o_stall_core <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_exc_req    <= 1'b0;
			o_exc_vector <= EXC_VECTOR_OFFSET;
		end else begin
			// Held until the core acknowledges
			o_exc_req    <= (state_next == ST_EXC);
			o_exc_vector <= EXC_VECTOR_OFFSET;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_illegal_trap <= 1'b0;
			o_addr_err     <= 1'b0;
		end else begin
			// Standby refuses ops; the register bus stays live
			o_illegal_trap <= i_op.valid && (state_reg == ST_IDLE) && standby_reg;
			o_addr_err     <= accept && misaligned;
		end
	end

endmodule

//--- rtl/fpu_exc_pkg.sv
// Constants, types and helpers for the FPU exception and special-result control.
// Assumes one 100 MHz core clock and a datapath that computes raw results.

package fpu_exc_pkg;

	////////////////////////////////////////////////////////////////////////////
	localparam logic [3:0]  OFS_STATUS_CTRL = 4'h0;
	localparam logic [3:0]  OFS_TRANSFER    = 4'h4;
	localparam logic [3:0]  OFS_STANDBY     = 4'h8;

	localparam int          DN_BIT      = 18;
	localparam int          CAUSE_V_BIT = 16;
	localparam int          CAUSE_Z_BIT = 15;
	localparam int          EN_V_BIT    = 11;
	localparam int          EN_Z_BIT    = 10;
	localparam int          FLAG_V_BIT  = 6;
	localparam int          FLAG_Z_BIT  = 5;
	localparam int          STANDBY_BIT = 1;

	localparam logic [31:0] SCR_FIXED      = 32'h0004_0001;
	localparam logic [31:0] TRANSFER_RESET = 32'h0000_0000;
	localparam logic        STANDBY_RESET  = 1'b0;

	localparam logic [31:0] VAL_QNAN  = 32'h7FBF_FFFF;
	localparam logic [31:0] VAL_MAX   = 32'h7F7F_FFFF;
	localparam logic [31:0] VAL_PINF  = 32'h7F80_0000;
	localparam logic [31:0] VAL_NINF  = 32'hFF80_0000;
	localparam logic [31:0] EXC_VECTOR_OFFSET = 32'h0000_0034;

	////////////////////////////////////////////////////////////////////////////
	typedef enum logic [3:0] {
		OP_ADD      = 4'h0,
		OP_SUB      = 4'h1,
		OP_MUL      = 4'h2,
		OP_DIV      = 4'h3,
		OP_CMP      = 4'h4,
		OP_TRUNC    = 4'h5,
		OP_FLOAT    = 4'h6,
		OP_MOV      = 4'h7,
		OP_LOAD     = 4'h8,
		OP_STORE    = 4'h9,
		OP_LDS_SC   = 4'hA,
		OP_STS_SC   = 4'hB,
		OP_LDS_XFER = 4'hC,
		OP_STS_XFER = 4'hD
	} op_kind_t;

	typedef struct packed {
		logic        valid;
		op_kind_t    kind;
		logic        addr_upd;
		logic [1:0]  addr_lo;
		logic [3:0]  dest;
		logic [3:0]  gpr;
		logic [31:0] a;
		logic [31:0] b;
	} op_req_t;

	typedef struct packed {
		logic        done;
		logic [31:0] data;
		logic        invalid;
		logic        div_zero;
		logic        overflow;
		logic        underflow;
		logic        inexact;
		logic        sign;
		logic        cmp_true;
	} dp_resp_t;

	typedef struct packed {
		logic        valid;
		op_kind_t    kind;
		logic [31:0] a;
		logic [31:0] b;
	} dp_start_t;

	typedef struct packed {
		logic        valid;
		logic [3:0]  idx;
		logic [31:0] data;
	} fr_wr_t;

	typedef struct packed {
		logic        valid;
		logic [3:0]  idx;
		logic        inc;
	} gpr_upd_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] data;
	} word_out_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_BUSY = 3'b010,
		ST_EXC  = 3'b100
	} ctrl_state_t;

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] flush_dn(input logic [31:0] v);
		flush_dn = (v[30:23] == 8'h00) ? {v[31], 31'h0000_0000} : v;
	endfunction

	function automatic logic is_snan(input logic [31:0] v);
		is_snan = (v[30:23] == 8'hFF) && v[22];
	endfunction

	function automatic logic uses_datapath(input op_kind_t k);
		uses_datapath = (k == OP_ADD) || (k == OP_SUB) || (k == OP_MUL) || (k == OP_DIV) ||
				(k == OP_CMP) || (k == OP_TRUNC) || (k == OP_FLOAT);
	endfunction

	function automatic logic needs_sync(input op_kind_t k);
		needs_sync = (k == OP_CMP) || (k == OP_TRUNC) || (k == OP_FLOAT) || (k >= OP_LOAD);
	endfunction

endpackage

//--- rtl/fpu_special_result.sv
// Replaces raw datapath results by the default special results.
// Assumes operands are already flushed and the response is valid.
`timescale 1ns/1ns

module fpu_special_result (
	input  fpu_exc_pkg::op_kind_t  i_kind,
	input  wire logic       [31:0] i_a,
	input  wire logic       [31:0] i_b,
	input  fpu_exc_pkg::dp_resp_t  i_resp,
	input  wire logic              i_en_v,
	input  wire logic              i_en_z,
	output logic            [31:0] o_data,
	output logic                   o_cause_v,
	output logic                   o_cause_z,
	output logic                   o_trap
);
	import fpu_exc_pkg::*;

	logic snan_in;
	logic anomaly;

	always_comb begin
		snan_in   = is_snan(i_a) || is_snan(i_b);
		anomaly   = ((i_kind == OP_ADD) || (i_kind == OP_SUB)) && (i_a == VAL_NINF) && (i_b == VAL_MAX);
		o_cause_v = i_resp.invalid || (snan_in && (i_kind != OP_FLOAT));
		o_cause_z = i_resp.div_zero && (i_kind == OP_DIV);
		o_trap    = (o_cause_v && i_en_v) || (o_cause_z && i_en_z);
		o_data    = flush_dn(i_resp.data);
		if (i_kind == OP_CMP || i_kind == OP_TRUNC) begin
			o_data = i_resp.data;
		end else if (o_cause_v) begin
			o_data = VAL_QNAN;
		end else if (o_cause_z) begin
			o_data = i_resp.sign ? VAL_NINF : VAL_PINF;
		end else if (anomaly) begin
			o_data = VAL_PINF;
		end else if (i_resp.overflow) begin
			o_data = {i_resp.sign, VAL_MAX[30:0]};
		end else if (i_resp.underflow) begin
			o_data = {i_resp.sign, 31'h0000_0000};
		end
	end

endmodule

//--- rtl/fpu_status_ctrl.sv
// Status/control register: enables, per-instruction cause, sticky flags.
// Assumes at most one software store and one hardware update per cycle.
`timescale 1ns/1ns

module fpu_status_ctrl (
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst,
	input  wire logic        i_sw_wr,
	input  wire logic [31:0] i_sw_data,
	input  wire logic        i_hw_upd,
	input  wire logic        i_hw_cause_v,
	input  wire logic        i_hw_cause_z,
	output logic      [31:0] o_scr
);
	import fpu_exc_pkg::*;

	logic cause_v_reg;
	logic cause_z_reg;
	logic en_v_reg;
	logic en_z_reg;
	logic flag_v_reg;
	logic flag_z_reg;

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			en_v_reg <= 1'b0;
			en_z_reg <= 1'b0;
		end else if (i_sw_wr) begin
			en_v_reg <= i_sw_data[EN_V_BIT];
			en_z_reg <= i_sw_data[EN_Z_BIT];
		end
	end

	// Cause follows the latest datapath instruction; a same-cycle store loses to it
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			cause_v_reg <= 1'b0;
			cause_z_reg <= 1'b0;
		end else if (i_hw_upd) begin
			cause_v_reg <= i_hw_cause_v;
			cause_z_reg <= i_hw_cause_z;
		end else if (i_sw_wr) begin
			cause_v_reg <= i_sw_data[CAUSE_V_BIT];
			cause_z_reg <= i_sw_data[CAUSE_Z_BIT];
		end
	end

	// Sticky flags, the set wins over a same-cycle store
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			flag_v_reg <= 1'b0;
			flag_z_reg <= 1'b0;
		end else begin
			flag_v_reg <= (i_sw_wr ? i_sw_data[FLAG_V_BIT] : flag_v_reg) | (i_hw_upd & i_hw_cause_v);
			flag_z_reg <= (i_sw_wr ? i_sw_data[FLAG_Z_BIT] : flag_z_reg) | (i_hw_upd & i_hw_cause_z);
		end
	end

	// Rounding field and denormal bit are constants
	always_comb begin
		o_scr = SCR_FIXED;
		o_scr[CAUSE_V_BIT] = cause_v_reg;
		o_scr[CAUSE_Z_BIT] = cause_z_reg;
		o_scr[EN_V_BIT]    = en_v_reg;
		o_scr[EN_Z_BIT]    = en_z_reg;
		o_scr[FLAG_V_BIT]  = flag_v_reg;
		o_scr[FLAG_Z_BIT]  = flag_z_reg;
	end

endmodule

//--- sim/fpu_dp_model.sv
// Behavioural datapath partner: answers each start with one done pulse.
// Assumes the bench sets the planned response and latency before issue.
`timescale 1ns/1ns

module fpu_dp_model
	import fpu_exc_pkg::*;
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst,
	input  dp_start_t        i_start,
	input  dp_resp_t         i_plan,
	input  wire logic [7:0]  i_dly,
	output dp_resp_t         o_resp
);
	initial o_resp = '0;

	////////////////////////////////////////////////////////////////////////////
	// Outside done the fields carry junk, never the last answer
	always @(posedge i_sys_clk) begin
		if (!i_rst && i_start.valid) begin
			repeat (i_dly) @(posedge i_sys_clk);
			o_resp <= {1'b1, i_plan[$bits(dp_resp_t)-2:0]};
			@(posedge i_sys_clk);
			o_resp <= {1'b0, ~i_plan[$bits(dp_resp_t)-2:0]};
		end
	end
endmodule

//--- sim/fpu_exc_ctrl_sva.sv
// Checker for the FPU exception control top.
// Assumes bind to fpu_exc_ctrl; watches its ports only.
`timescale 1ns/1ns

module fpu_exc_chk
	import fpu_exc_pkg::*;
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst,
	input  wire logic        i_exc_ack,
	input  dp_start_t        o_dp_start,
	input  fr_wr_t           o_fr_wr,
	input  wire logic        o_t_valid,
	input  wire logic        o_fp_ready,
	input  wire logic        o_stall_core,
	input  wire logic        o_exc_req,
	input  wire logic [31:0] o_exc_vector,
	input  wire logic        o_illegal_trap
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	////////////////////////////////////////////////////////////////////////////
	a_vector_fixed: assert property (o_exc_vector == 32'h0000_0034)
		else $error("exception vector not fixed");
	a_req_held: assert property (o_exc_req && !i_exc_ack |=> o_exc_req)
		else $error("exception request dropped before ack");
	a_req_drop: assert property (o_exc_req && i_exc_ack |=> !o_exc_req)
		else $error("exception request kept after ack");
	a_trap_no_dest: assert property ($rose(o_exc_req) |-> !o_fr_wr.valid)
		else $error("destination written on trap");
	a_standby_quiet: assert property (o_illegal_trap |-> !o_dp_start.valid && !o_fr_wr.valid)
		else $error("op executed in standby");
	a_arith_no_stall: assert property (o_dp_start.valid && o_dp_start.kind inside {OP_ADD, OP_SUB, OP_MUL, OP_DIV}
		|-> !o_stall_core)
		else $error("arithmetic op stalls core");
	a_cmp_stall: assert property (o_dp_start.valid && o_dp_start.kind == OP_CMP |-> o_stall_core)
		else $error("compare not interlocked");
	a_t_after_sync: assert property (o_t_valid |-> $past(o_stall_core))
		else $error("flag written without interlock");
	a_busy_on_start: assert property (o_dp_start.valid |-> !o_fp_ready ##1 !o_fp_ready)
		else $error("ready while op in flight");
endmodule

bind fpu_exc_ctrl fpu_exc_chk fpu_exc_chk_inst (
	.i_sys_clk     (i_sys_clk),
	.i_rst         (i_rst),
	.i_exc_ack     (i_exc_ack),
	.o_dp_start    (o_dp_start),
	.o_fr_wr       (o_fr_wr),
	.o_t_valid     (o_t_valid),
	.o_fp_ready    (o_fp_ready),
	.o_stall_core  (o_stall_core),
	.o_exc_req     (o_exc_req),
	.o_exc_vector  (o_exc_vector),
	.o_illegal_trap(o_illegal_trap)
);

//--- sim/testbench.sv
// Self-checking bench for the FPU exception control.
// Assumes the datapath partner model and the bound checker.
`timescale 1ns/1ns

module testbench;
	import fpu_exc_pkg::*;
	logic clk = 0, rst = 1, wr = 0, rd = 0, ack = 0;
	logic [3:0] addr = '0;
	logic [31:0] wdata = '0, rdata;
	op_req_t op = '0;
	dp_resp_t resp, plan = '0;
	logic [7:0] dly = 8'h01;
	dp_start_t start;
	fr_wr_t frw;
	gpr_upd_t gpu;
	word_out_t cpw;
	logic t_v, t_val, rdy, stall, exc, ill, aerr;
	logic [31:0] vec;
	int mismatches = 0, samples_checked = 0;

	always #5 clk = ~clk;

	fpu_exc_ctrl fpu_exc_ctrl_inst (.i_sys_clk(clk), .i_rst(rst), .i_reg_addr(addr),
		.i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_op(op),
		.i_dp_resp(resp), .i_exc_ack(ack), .o_dp_start(start), .o_fr_wr(frw), .o_gpr_upd(gpu),
		.o_cpu_wr(cpw), .o_t_valid(t_v), .o_t_value(t_val), .o_fp_ready(rdy),
		.o_stall_core(stall), .o_exc_req(exc), .o_exc_vector(vec), .o_illegal_trap(ill),
		.o_addr_err(aerr));
	fpu_dp_model fpu_dp_model_inst (.i_sys_clk(clk), .i_rst(rst), .i_start(start),
		.i_plan(plan), .i_dly(dly), .o_resp(resp));

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wreg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk) {wr, addr, wdata} <= {1'b1, a, d};
		@(posedge clk) wr <= 1'b0;
	endtask

	task automatic rreg(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk) {rd, addr} <= {1'b1, a};
		@(posedge clk) rd <= 1'b0;
		#1 chk(rdata, e);
	endtask

	task automatic issue(input op_req_t o);
		@(posedge clk) op <= o;
		@(posedge clk) op.valid <= 1'b0;
		#1;
	endtask

	// m: 0 register result, 1 flag result, 2 trap, 3 no destination
	task automatic run(input op_kind_t k, input logic [31:0] a, b, raw, input logic [6:0] f,
			input logic [1:0] m, input logic [31:0] e);
		plan <= '{1'b0, raw, f[6], f[5], f[4], f[3], f[2], f[1], f[0]};
		dly <= (k == OP_DIV) ? 8'h0C : 8'h01;
		issue('{1'b1, k, 1'b0, 2'b00, 4'h3, 4'h1, a, b});
		chk(stall, k inside {OP_CMP, OP_TRUNC, OP_FLOAT});
		chk({start.valid, start.kind}, {1'b1, k});
		for (int n = 0; n < 40 && !(frw.valid | t_v | exc | rdy); n++) @(posedge clk) #1;
		case (m)
			2'd0: chk({frw.valid, frw.data}, {1'b1, e});
			2'd1: chk({t_v, t_val}, {1'b1, e[0]});
			2'd2: chk({exc, frw.valid}, 2'b10);
			default: chk({frw.valid, t_v, exc, rdy}, 4'b0001);
		endcase
	endtask

	task automatic take_exc();
		repeat (3) @(posedge clk) #1 chk(exc, 1'b1);
		@(posedge clk) ack <= 1'b1;
		@(posedge clk) ack <= 1'b0;
		#1 chk({exc, rdy}, 2'b01);
	endtask

	task automatic wrap_up();
		$display("checks=%0d mismatches=%0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		#200000;
		mismatches++;
		wrap_up();
	end

	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		chk(vec, 32'h0000_0034);
		chk(vec[1:0], 2'b00);
		rreg(4'h0, 32'h0004_0001);
		rreg(4'h8, 32'h0000_0000);
		rreg(4'hC, 32'h0000_0000);
		wreg(4'h0, 32'hFFFF_FFFF);
		rreg(4'h0, 32'h0005_8C61);
		wreg(4'h0, 32'h0000_0000);
		rreg(4'h0, 32'h0004_0001);
		wreg(4'h4, 32'hDEAD_BEEF);
		rreg(4'h4, 32'hDEAD_BEEF);
		run(OP_ADD, 32'h7FC0_0000, 32'h3F80_0000, 32'h7FC0_0000, 7'h40, 0, VAL_QNAN);
		run(OP_DIV, 32'h3F80_0000, 32'h0, 32'h0, 7'h22, 0, VAL_NINF);
		run(OP_MUL, 32'hFF00_0000, 32'h7F00_0000, 32'h0, 7'h12, 0, 32'hFF7F_FFFF);
		run(OP_MUL, 32'h8080_0000, 32'h0080_0000, 32'h1, 7'h0A, 0, 32'h8000_0000);
		run(OP_ADD, 32'h3F80_0000, 32'h3400_0000, 32'h3F80_0001, 7'h04, 0, 32'h3F80_0001);
		run(OP_ADD, VAL_NINF, VAL_MAX, VAL_NINF, 7'h00, 0, VAL_PINF);
		run(OP_SUB, VAL_NINF, VAL_MAX, VAL_NINF, 7'h00, 0, VAL_PINF);
		run(OP_ADD, 32'h0080_0000, 32'h8080_0001, 32'h0000_0123, 7'h00, 0, 32'h0);
		run(OP_DIV, 32'h4000_0000, 32'h3F80_0000, 32'h4000_0000, 7'h00, 0, 32'h4000_0000);
		run(OP_TRUNC, 32'h4F80_0000, 32'h0, 32'h7FFF_FFFF, 7'h40, 3, 32'h0);
		rreg(4'h4, 32'h7FFF_FFFF);
		run(OP_FLOAT, 32'h0, 32'h0, 32'h4EFF_FFFF, 7'h00, 0, 32'h4EFF_FFFF);
		run(OP_CMP, 32'h7FC0_0000, 32'h0, 32'h0, 7'h41, 1, 32'h0);
		run(OP_CMP, 32'h3F80_0000, 32'h3F80_0000, 32'h0, 7'h01, 1, 32'h1);
		rreg(4'h0, 32'h0004_0061);
		wreg(4'h0, 32'h0000_0C00);
		rreg(4'h0, 32'h0004_0C01);
		run(OP_DIV, 32'h3F80_0000, 32'h0, 32'h0, 7'h20, 2, 32'h0);
		rreg(4'h0, 32'h0004_8C21);
		take_exc();
		run(OP_ADD, 32'h7FC0_0000, 32'h3F80_0000, 32'h7FC0_0000, 7'h40, 2, 32'h0);
		take_exc();
		rreg(4'h0, 32'h0005_0C61);
		issue('{1'b1, OP_LOAD, 1'b1, 2'b00, 4'h2, 4'h5, 32'h1234_5678, 32'h0});
		chk({frw.valid, frw.data, gpu.valid, gpu.idx, gpu.inc}, {1'b1, 32'h1234_5678, 6'h2B});
		issue('{1'b1, OP_STORE, 1'b1, 2'b00, 4'h2, 4'h6, 32'h0BAD_F00D, 32'h0});
		chk({cpw.valid, cpw.data, gpu.valid, gpu.idx, gpu.inc}, {1'b1, 32'h0BAD_F00D, 6'h2C});
		issue('{1'b1, OP_LOAD, 1'b0, 2'b10, 4'h2, 4'h5, 32'h1, 32'h0});
		chk({aerr, frw.valid}, 2'b10);
		issue('{1'b1, OP_MOV, 1'b0, 2'b00, 4'h7, 4'h0, 32'h0000_0005, 32'h0});
		chk({frw.valid, frw.idx, frw.data}, {1'b1, 4'h7, 32'h0000_0005});
		issue('{1'b1, OP_LDS_XFER, 1'b0, 2'b00, 4'h0, 4'h0, 32'h0, 32'h1357_9BDF});
		issue('{1'b1, OP_STS_XFER, 1'b0, 2'b00, 4'h0, 4'h0, 32'h0, 32'h0});
		chk({cpw.valid, cpw.data}, {1'b1, 32'h1357_9BDF});
		issue('{1'b1, OP_LDS_SC, 1'b0, 2'b00, 4'h0, 4'h0, 32'h0, 32'hFFFF_F3FF});
		issue('{1'b1, OP_STS_SC, 1'b0, 2'b00, 4'h0, 4'h0, 32'h0, 32'h0});
		chk({cpw.valid, cpw.data}, {1'b1, 32'h0005_8061});
		wreg(4'h8, 32'h0000_0002);
		rreg(4'h8, 32'h0000_0002);
		issue('{1'b1, OP_ADD, 1'b0, 2'b00, 4'h3, 4'h1, 32'h0, 32'h0});
		chk({ill, start.valid}, 2'b10);
		wreg(4'h8, 32'h0000_0000);
		repeat (3) @(posedge clk);
		wrap_up();
	end
endmodule
